// *** hw/asp_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module asp_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  input wire logic wclk_i,
  output logic wclk_o,
  output logic wclk_oe,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  input wire logic [31:0] adc_data,
  output logic [31:0] dac_data,
  output logic dac_valid
);
  import asp_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] offset;
    logic [6:0] bdiv;
    logic [8:0] dac_len;
    logic [8:0] adc_len;
    logic [6:0] pwr;
    logic [2:0] bclk_sy;
    logic [1:0] wclk_sy;
    logic [1:0] din_sy;
    logic [8:0] pos;
    logic lvl;
    logic wclk_prev;
    logic wclk_out;
    logic dout;
    logic dout_act;
    logic [31:0] tx_word;
    logic [31:0] rx_sh;
    logic [31:0] rx_left;
    logic [31:0] dac_data;
    logic dac_valid;
    logic [15:0] frames;
    logic [31:0] prdata;
    logic pslverr;
  } asp_state_t;

  asp_state_t s;
  asp_state_t next_s;
  logic [1:0] rst_sync;
  logic rst_n;
  logic div_bclk;
  logic div_rise;
  logic div_fall;
  logic div_en;

  function automatic logic [6:0] asp_slot(input logic [1:0] fmt, input logic [9:0] p,
                                          input logic [9:0] off, input logic [9:0] wl,
                                          input logic [9:0] seg);
    logic [9:0] st;
    logic [9:0] rel;
    unique case (fmt)
      ASP_FMT_I2S: st = off + 10'h001; // [RL2]
      ASP_FMT_DSP: st = (p >= off + wl) ? off + wl : off; // [RL3]
      ASP_FMT_RJ: st = seg - wl + off; // [RL15]
      ASP_FMT_LJ: st = off; // [RL17]
    endcase
    rel = p - st;
    return {(p >= st) && (rel < wl), rel[5:0]}; // [RL10]
  endfunction

  // Release of the asynchronous reset is retimed onto clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [1:0] fmt;
  logic is_dsp;
  logic [9:0] wl;
  logic [9:0] off;
  logic [8:0] frame_len;
  logic [9:0] seg;
  logic iface_en;
  logic clocks_run;
  logic bclk_mst;
  logic wclk_mst;
  logic pin_rise;
  logic pin_fall;
  logic samp_e;
  logic launch_e;

  always_comb begin
    fmt = s.ctrl[ASP_CTRL_FMT +: 2]; // [RL1]
    is_dsp = (fmt == ASP_FMT_DSP);
    unique case (s.ctrl[ASP_CTRL_WLEN +: 2]) // [RL4]
      2'h0: wl = 10'h010;
      2'h1: wl = 10'h014;
      2'h2: wl = 10'h018;
      2'h3: wl = 10'h020;
    endcase
    off = {2'h0, s.offset};
    // Shorter frame wins: the faster of the two powered converters paces the word clock
    if (s.pwr[ASP_PWR_ADC] && !s.pwr[ASP_PWR_DAC]) begin // [RL7]
      frame_len = s.adc_len;
    end else if (s.pwr[ASP_PWR_DAC] && !s.pwr[ASP_PWR_ADC]) begin
      frame_len = s.dac_len;
    end else begin
      frame_len = (s.adc_len < s.dac_len) ? s.adc_len : s.dac_len;
    end
    seg = is_dsp ? {1'b0, frame_len} : {2'h0, frame_len[8:1]};
    iface_en = s.pwr[ASP_PWR_IFACE];
    clocks_run = iface_en && (s.pwr[ASP_PWR_ADC] || s.pwr[ASP_PWR_DAC]
                              || s.pwr[ASP_PWR_KEEP]); // [RL14]
    bclk_mst = s.ctrl[ASP_CTRL_BCLK_MST]; // [RL5]
    wclk_mst = s.ctrl[ASP_CTRL_WCLK_MST]; // [RL5]
    div_en = clocks_run && bclk_mst;
    if (bclk_mst) begin
      pin_rise = div_rise;
      pin_fall = div_fall;
    end else begin
      pin_rise = iface_en && s.bclk_sy[1] && !s.bclk_sy[2];
      pin_fall = iface_en && !s.bclk_sy[1] && s.bclk_sy[2];
    end
    // DSP samples on the falling pin edge; the invert bit swaps both edges
    samp_e = (is_dsp ^ s.pwr[ASP_PWR_INV]) ? pin_fall : pin_rise; // [RL11]
    launch_e = (is_dsp ^ s.pwr[ASP_PWR_INV]) ? pin_rise : pin_fall; // [RL11]
  end

  asp_bclk_div #(
    .DIV_W(7)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .en(div_en),
    .ratio(s.bdiv),
    .bclk(div_bclk),
    .rise(div_rise),
    .fall(div_fall)
  );

  logic [9:0] p_cur;
  logic l_cur;
  logic [9:0] p_nxt;
  logic l_nxt;
  logic [6:0] slot;
  logic right;
  logic [31:0] word;
  logic [31:0] rx_new;
  logic [31:0] rx_al;
  logic [32:0] avg;
  logic w_in;
  logic setup;
  logic [7:0] a;

  always_comb begin
    next_s = s;
    p_cur = {1'b0, s.pos};
    l_cur = s.lvl;
    p_nxt = 10'h000;
    l_nxt = s.lvl;
    slot = 7'h00;
    right = 1'b0;
    word = s.tx_word;
    rx_new = 32'h0000_0000;
    rx_al = 32'h0000_0000;
    avg = 33'h0_0000_0000;
    w_in = s.wclk_sy[1];
    setup = psel && !penable;
    a = paddr;
    next_s.dac_valid = 1'b0;
    next_s.bclk_sy = {s.bclk_sy[1:0], bclk_i};
    next_s.wclk_sy = {s.wclk_sy[0], wclk_i};
    next_s.din_sy = {s.din_sy[0], din};

    if (!iface_en || (bclk_mst && !clocks_run)) begin
      next_s.pos = 9'h000;
      next_s.lvl = 1'b0;
      next_s.dout = 1'b0;
      next_s.dout_act = 1'b0;
      next_s.wclk_out = 1'b0;
    end else begin
      if (launch_e) begin
        if (p_cur + 10'h001 >= seg) begin
          p_nxt = 10'h000;
          l_nxt = !s.lvl;
        end else begin
          p_nxt = p_cur + 10'h001;
        end
        // Word taken at the first slot of each frame, so one sample fills both channels
        if (p_nxt == 10'h000 && (is_dsp || (l_nxt == (fmt == ASP_FMT_I2S ? 1'b0 : 1'b1)))) begin
          word = adc_data; // [RL21]
          next_s.tx_word = adc_data;
        end
        slot = asp_slot(fmt, p_nxt, off, wl, seg);
        next_s.pos = p_nxt[8:0];
        next_s.lvl = l_nxt;
        next_s.dout = slot[6] && word[5'd31 - slot[4:0]]; // [RL20] [RL4]
        next_s.dout_act = slot[6];
        if (s.ctrl[ASP_CTRL_WCLK_PULSE]) begin
          next_s.wclk_out = (p_nxt + 10'h001 == seg) && (is_dsp || l_nxt); // [RL6]
        end else begin
          next_s.wclk_out = is_dsp ? (p_nxt >= {1'b0, seg[9:1]}) : l_nxt; // [RL6]
        end
      end
      if (samp_e) begin
        if (!wclk_mst) begin
          next_s.wclk_prev = w_in;
          // Realign to the far party's word clock; DSP frames restart only on falling edge
          if (w_in != s.wclk_prev && (!is_dsp || !w_in)) begin
            p_cur = 10'h000;
            l_cur = w_in;
            next_s.pos = 9'h000;
            next_s.lvl = w_in;
          end
        end
        slot = asp_slot(fmt, p_cur, off, wl, seg);
        unique case (fmt)
          ASP_FMT_I2S: right = l_cur;
          ASP_FMT_DSP: right = (p_cur >= off + wl);
          ASP_FMT_RJ: right = !l_cur;
          ASP_FMT_LJ: right = !l_cur;
        endcase
        if (slot[6]) begin
          rx_new = {s.rx_sh[30:0], s.din_sy[1]}; // [RL4]
          next_s.rx_sh = rx_new;
          rx_al = rx_new << (6'd32 - wl[5:0]);
          if ({4'h0, slot[5:0]} == wl - 10'h001) begin
            if (!right) begin
              next_s.rx_left = rx_al;
            end else begin
              avg = {s.rx_left[31], s.rx_left} + {rx_al[31], rx_al};
              unique case (s.pwr[ASP_PWR_MONO +: 2]) // [RL19]
                ASP_MONO_LEFT: next_s.dac_data = s.rx_left;
                ASP_MONO_RIGHT: next_s.dac_data = rx_al;
                ASP_MONO_AVG, ASP_MONO_AVG2: next_s.dac_data = avg[32:1];
              endcase
              next_s.dac_valid = 1'b1; // [RL21]
              next_s.frames = s.frames + 16'h0001;
            end
          end
        end
      end
    end

    if (setup) begin
      next_s.pslverr = 1'b0;
      unique case (a)
        ASP_OFS_CTRL: next_s.prdata = {24'h000000, s.ctrl};
        ASP_OFS_OFFSET: next_s.prdata = {24'h000000, s.offset};
        ASP_OFS_BDIV: next_s.prdata = {25'h0000000, s.bdiv};
        ASP_OFS_DAC_LEN: next_s.prdata = {23'h000000, s.dac_len};
        ASP_OFS_ADC_LEN: next_s.prdata = {23'h000000, s.adc_len};
        ASP_OFS_PWR: next_s.prdata = {25'h0000000, s.pwr};
        ASP_OFS_STATUS: next_s.prdata = {s.frames, 13'h0000, clocks_run, s.lvl, s.wclk_out};
        ASP_OFS_RXDATA: next_s.prdata = s.dac_data;
        default: begin
          next_s.prdata = 32'h0000_0000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite) begin
      unique case (a)
        ASP_OFS_CTRL: next_s.ctrl = pwdata[7:0];
        ASP_OFS_OFFSET: next_s.offset = pwdata[7:0]; // [RL10]
        ASP_OFS_BDIV: next_s.bdiv = pwdata[6:0]; // [RL9]
        ASP_OFS_DAC_LEN: next_s.dac_len = pwdata[8:0];
        ASP_OFS_ADC_LEN: next_s.adc_len = pwdata[8:0];
        ASP_OFS_PWR: next_s.pwr = pwdata[6:0];
        default: next_s.pslverr = s.pslverr;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= ASP_RST_CTRL;
      s.offset <= ASP_RST_OFFSET;
      s.bdiv <= ASP_RST_BDIV;
      s.dac_len <= ASP_RST_LEN;
      s.adc_len <= ASP_RST_LEN;
      s.pwr <= ASP_RST_PWR;
    end else begin
      s <= next_s;
    end
  end

  // Powered-down interface floats every pin it could drive
  assign bclk_oe = iface_en && bclk_mst; // [RL13]
  assign wclk_oe = iface_en && wclk_mst; // [RL13]
  assign dout_oe = iface_en && (!s.ctrl[ASP_CTRL_TRISTATE] || s.dout_act); // [RL12] [RL13]
  assign bclk_o = div_bclk;
  assign wclk_o = s.wclk_out;
  assign dout_o = s.dout;
  assign dac_data = s.dac_data;
  assign dac_valid = s.dac_valid;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign pready = 1'b1;
endmodule
`default_nettype wire

// *** hw/asp_pkg.sv ***
// Contract
// [RL1] Format field two bits: 10 right-justified, 11 left-justified.
// [RL2] Format 00 is I2S: each MSB on second rising bit clock after word clock edge.
// [RL3] Format 01 is DSP: falling word clock starts frame, left then right, falling-edge valid.
// [RL4] Every format sends MSB first; word length field selects 16, 20, 24 or 32.
// [RL5] Word clock and bit clock are each master or slave independently.
// [RL6] Word clock marks frame start; shape selectable as pulse or square wave.
// [RL7] Word clock rate equals the higher of the ADC and DAC sample rates.
// [RL8] Master bit clock comes from a programmable divider.
// [RL9] Divider ratio is a seven-bit field covering 1 to 128.
// [RL10] First data bit is delayed from frame start by a programmed bit-clock offset.
// [RL11] A control bit inverts the data bit-clock polarity in every format.
// [RL12] Optional high-impedance data output during every bit clock without valid data.
// [RL13] Interface powered down while master puts all interface pins high-impedance.
// [RL14] Master clocks run only while a converter is powered, unless kept running. A master word clock on a slave bit clock keeps running regardless.
// [RL15] Right-justified: each LSB valid on rising edge just before its word clock edge.
// [RL16] Right-justified: host sets frame at least twice the word length.
// [RL17] Left-justified: each MSB valid on first rising edge after its word clock edge.
// [RL18] Left-justified: frame at least twice word length; offset leaves room for a word.
// [RL19] Two-bit field picks DAC input: left, right or average of both.
// [RL20] The mono ADC sample is sent in both left and right slots.
// [RL21] Received word goes to DAC once per frame; transmit word loaded before each frame.
package asp_pkg;
  localparam logic [7:0] ASP_OFS_CTRL = 8'h00;
  localparam logic [7:0] ASP_OFS_OFFSET = 8'h04;
  localparam logic [7:0] ASP_OFS_BDIV = 8'h08;
  localparam logic [7:0] ASP_OFS_DAC_LEN = 8'h0C;
  localparam logic [7:0] ASP_OFS_ADC_LEN = 8'h10;
  localparam logic [7:0] ASP_OFS_PWR = 8'h14;
  localparam logic [7:0] ASP_OFS_STATUS = 8'h18;
  localparam logic [7:0] ASP_OFS_RXDATA = 8'h1C;
  // Control register fields
  localparam int ASP_CTRL_FMT = 6;
  localparam int ASP_CTRL_WLEN = 4;
  localparam int ASP_CTRL_BCLK_MST = 3;
  localparam int ASP_CTRL_WCLK_MST = 2;
  localparam int ASP_CTRL_WCLK_PULSE = 1;
  localparam int ASP_CTRL_TRISTATE = 0;
  // Power register fields
  localparam int ASP_PWR_IFACE = 0;
  localparam int ASP_PWR_ADC = 1;
  localparam int ASP_PWR_DAC = 2;
  localparam int ASP_PWR_KEEP = 3;
  localparam int ASP_PWR_INV = 4;
  localparam int ASP_PWR_MONO = 5;
  // Reset values
  localparam logic [7:0] ASP_RST_CTRL = 8'h00;
  localparam logic [7:0] ASP_RST_OFFSET = 8'h00;
  localparam logic [6:0] ASP_RST_BDIV = 7'h01;
  localparam logic [8:0] ASP_RST_LEN = 9'h040;
  localparam logic [6:0] ASP_RST_PWR = 7'h00;
  typedef enum logic [1:0] {
    ASP_FMT_I2S = 2'h0,
    ASP_FMT_DSP = 2'h1,
    ASP_FMT_RJ = 2'h2,
    ASP_FMT_LJ = 2'h3
  } asp_fmt_t;
  typedef enum logic [1:0] {
    ASP_MONO_LEFT = 2'h0,
    ASP_MONO_RIGHT = 2'h1,
    ASP_MONO_AVG = 2'h2,
    ASP_MONO_AVG2 = 2'h3
  } asp_mono_t;
endpackage

// *** hw/asp_bclk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module asp_bclk_div #(
  parameter int DIV_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [DIV_W-1:0] ratio,
  output logic bclk,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic bclk;
  } asp_div_t;
  asp_div_t s;
  asp_div_t next_s;
  logic tick;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("asp_bclk_div: DIV_W out of range");
  end

  // Ratio 0 stands for the full 2**DIV_W; counter wraps naturally there
  assign tick = en && (s.cnt == ratio - {{(DIV_W-1){1'b0}}, 1'b1}); // [RL9]
  assign rise = tick && !s.bclk;
  assign fall = tick && s.bclk;
  assign bclk = s.bclk;

  always_comb begin
    next_s = s;
    if (!en) begin
      next_s.cnt = '0;
      next_s.bclk = 1'b0;
    end else if (tick) begin
      next_s.cnt = '0;
      next_s.bclk = !s.bclk; // [RL8]
    end else begin
      next_s.cnt = s.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// *** tb/asp_core_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module asp_core_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic bclk_o,
  input wire logic bclk_oe,
  input wire logic wclk_oe,
  input wire logic dout_oe,
  input wire logic [31:0] dac_data,
  input wire logic dac_valid
);
  logic [7:0] ctrl;
  logic [6:0] pwr;
  logic [6:0] bdiv;
  logic [8:0] hcnt;
  logic [8:0] fcnt;
  logic [1:0] ok;
  wire logic wr = psel & penable & pwrite & pready;
  wire logic on = pwr[0];
  wire logic frz = on & ctrl[3] & ~|pwr[3:1];
  wire logic [7:0] ratio = (bdiv == 7'h00) ? 8'h80 : {1'b0, bdiv};
  // Shadow copies of the registers that steer the pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 8'h00;
      pwr <= 7'h00;
      bdiv <= 7'h01;
      hcnt <= 9'h000;
      fcnt <= 9'h000;
      ok <= 2'h0;
    end else begin
      if (wr && paddr == 8'h00) ctrl <= pwdata[7:0];
      if (wr && paddr == 8'h08) bdiv <= pwdata[6:0];
      if (wr && paddr == 8'h14) pwr <= pwdata[6:0];
      hcnt <= $changed(bclk_o) ? 9'h000 : hcnt + 9'h001;
      fcnt <= !frz ? 9'h000 : (fcnt == 9'h12C) ? fcnt : fcnt + 9'h001;
      // Skip three half periods after any write: the divider may restart
      ok <= wr ? 2'h0 : ($changed(bclk_o) && ok != 2'h3) ? ok + 2'h1 : ok;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  pins_hiz_a: assert property (!on |-> !bclk_oe && !wclk_oe && !dout_oe)
    else $error("pins driven while interface off");
  bclk_dir_a: assert property (bclk_oe == (on && ctrl[3]))
    else $error("bit clock direction wrong");
  wclk_dir_a: assert property (wclk_oe == (on && ctrl[2]))
    else $error("word clock direction wrong");
  dout_drive_a: assert property (on && !ctrl[0] |-> dout_oe)
    else $error("data output released without tristate");
  clk_freeze_a: assert property (fcnt == 9'h12C |-> !bclk_o)
    else $error("bit clock runs with converters off");
  bclk_half_a: assert property (ctrl[3] && $changed(bclk_o) && ok == 2'h3 |->
    hcnt + 9'h001 == {1'b0, ratio}) else $error("bit clock half period wrong");
  dac_pulse_a: assert property (dac_valid |=> !dac_valid)
    else $error("word strobe longer than one cycle");
  dac_hold_a: assert property ($changed(dac_data) |-> dac_valid || $past(dac_valid))
    else $error("received word changed without strobe");
  cover property (dac_valid);
  cover property (fcnt == 9'h12C);
  cover property ($changed(bclk_o) && ok == 2'h3 && ratio == 8'h80);
endmodule
`default_nettype wire

// *** tb/asp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
  input wire logic clk,
  input wire logic bclk,
  input wire logic wclk,
  input wire logic dline,
  input wire logic samp_rise,
  input wire logic [31:0] word_hi,
  input wire logic [31:0] word_lo,
  output logic din,
  output logic [31:0] snap_hi,
  output logic [31:0] snap_lo
);
  logic pb = 1'b0;
  logic pw = 1'b0;
  logic [31:0] sr = 32'h0;
  logic [31:0] tx = 32'h0;
  initial begin
    din = 1'b0;
    snap_hi = 32'h0;
    snap_lo = 32'h0;
  end
  always @(posedge clk) begin
    pb <= bclk;
    pw <= wclk;
    if (bclk != pb && bclk == samp_rise) sr <= {sr[30:0], dline};
    // Each word clock level restarts a half, MSB first
    if (wclk != pw) begin
      if (pw) snap_hi <= sr;
      else snap_lo <= sr;
      tx <= (wclk ? word_hi : word_lo) << 1;
      din <= wclk ? word_hi[31] : word_lo[31];
    end else if (bclk != pb && bclk != samp_rise) begin
      tx <= tx << 1;
      din <= tx[31];
    end
  end
endmodule
`default_nettype wire

// *** tb/asp_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module asp_core_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] adc_data = 32'h0;
  logic [31:0] word_hi = 32'h0;
  logic [31:0] word_lo = 32'h0;
  logic samp_rise = 1'b1;
  logic oe_low = 1'b0;
  logic [31:0] prdata, dac_data, snap_hi, snap_lo, rd, ea, m;
  logic pready, pslverr, bclk_o, bclk_oe, wclk_o, wclk_oe, dout_o, dout_oe, dac_valid, din, err;
  logic [15:0] lf = 16'h6359;
  logic [15:0] l, r, dv;
  logic [8:0] row;
  logic [8:0] rows [5] = '{9'h180, 9'h1E2, 9'h104, 9'h000, 9'h053};
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t, t0;
  wire logic bclk_w = bclk_oe ? bclk_o : 1'b0;
  wire logic wclk_w = wclk_oe ? wclk_o : 1'b0;
  // Released data line toggles so a stale bit cannot pass
  wire logic dline = dout_oe ? dout_o : cyc[0];
  asp_core u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wclk_i(wclk_w), .wclk_o(wclk_o),
    .wclk_oe(wclk_oe), .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .adc_data(adc_data),
    .dac_data(dac_data), .dac_valid(dac_valid));
  asp_host_model u_host (.clk(clk), .bclk(bclk_w), .wclk(wclk_w), .dline(dline),
    .samp_rise(samp_rise), .word_hi(word_hi), .word_lo(word_lo), .din(din),
    .snap_hi(snap_hi), .snap_lo(snap_lo));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dout_oe === 1'b0) oe_low <= 1'b1;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] al(input logic [1:0] f, input logic [15:0] w, input int off);
    return (f == 2'h2) ? {16'h0000, w} : ({w, 16'h0000} >> (off + int'(f == 2'h0)));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task frames(input int n);
    repeat (n) begin
      do @(negedge clk); while (dac_valid !== 1'b1);
    end
  endtask
  task period(input int exp);
    frames(2);
    t0 = cyc;
    frames(1);
    chk(32'(cyc - t0), 32'(exp));
  endtask
  task toggles(input int n);
    t = 0;
    repeat (n) begin
      l[0] = bclk_o;
      @(negedge clk);
      if (bclk_o !== l[0]) t++;
    end
  endtask
  task highs(input int exp);
    frames(2);
    t = 0;
    do begin
      @(negedge clk);
      if (wclk_o === 1'b1) t++;
    end while (dac_valid !== 1'b1);
    chk(32'(t), 32'(exp));
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h40);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h08, 32'h6);
    // Frame 64 bits, offsets well inside it
    for (int i = 0; i < 5; i++) begin
      row = rows[i];
      apb(1'b1, 8'h04, {29'h0, row[5:3]});
      lf = nxt(lf);
      adc_data <= {lf, ~lf};
      ea = al(row[8:7], lf, int'(row[5:3]));
      lf = nxt(lf);
      l = lf & 16'h7FFE;
      lf = nxt(lf);
      r = lf & 16'h7FFE;
      word_hi <= al(row[8:7], (row[8:7] == 2'h0) ? r : l, int'(row[5:3]));
      word_lo <= al(row[8:7], (row[8:7] == 2'h0) ? l : r, int'(row[5:3]));
      samp_rise <= ~row[6];
      apb(1'b1, 8'h00, {24'h0, row[8:7], 5'h06, row[0]});
      apb(1'b1, 8'h14, {25'h0, row[2:1], row[6], 4'h7});
      frames(1);
      oe_low = 1'b0;
      frames(2);
      m = row[0] ? al(row[8:7], 16'hFFFF, int'(row[5:3])) : 32'hFFFFFFFF;
      chk(snap_hi & m, ea);
      chk(snap_lo & m, ea);
      dv = (row[2:1] == 2'h0) ? l : (row[2:1] == 2'h1) ? r : 16'(({1'b0, l} + {1'b0, r}) >> 1);
      chk(dac_data, {dv, 16'h0000});
      apb(1'b0, 8'h1C, 32'h0);
      chk(rd, {dv, 16'h0000});
      chk({31'h0, oe_low}, {31'h0, row[0]});
    end
    apb(1'b1, 8'h00, 32'h4C);
    period(768);
    apb(1'b1, 8'h00, 32'hCC);
    apb(1'b1, 8'h0C, 32'h30);
    period(576);
    // Square word clock: high for one half of a 48-bit frame
    highs(288);
    apb(1'b1, 8'h00, 32'hCE);
    // Pulse word clock: high for one bit period per frame
    highs(12);
    apb(1'b1, 8'h0C, 32'h40);
    apb(1'b1, 8'h00, 32'hC8);
    @(negedge clk);
    chk({30'h0, bclk_oe, wclk_oe}, 32'h2);
    apb(1'b1, 8'h14, 32'h1);
    repeat (350) @(negedge clk);
    toggles(240);
    chk(32'(t), 32'h0);
    apb(1'b1, 8'h14, 32'h9);
    repeat (20) @(negedge clk);
    toggles(240);
    chk(32'(t), 32'h28);
    apb(1'b1, 8'h08, 32'h0);
    repeat (300) @(negedge clk);
    toggles(1024);
    chk(32'(t), 32'h8);
    apb(1'b1, 8'h14, 32'h0);
    @(negedge clk);
    chk({29'h0, bclk_oe, wclk_oe, dout_oe}, 32'h0);
    summarize();
  end
endmodule
bind asp_core asp_core_assertions u_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wclk_oe(wclk_oe), .dout_oe(dout_oe),
  .dac_data(dac_data), .dac_valid(dac_valid));
`default_nettype wire
